// >>> inc/emlc_pkg.sv
package emlc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned RAM_AW = 12;
   localparam int unsigned RAM_DEPTH = 4096;

   ////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on the Wishbone side
   localparam logic [3:0] REG_CONFIG = 4'h0;
   localparam logic [3:0] REG_PAGE = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;

   localparam logic [7:0] CONFIG_RST = 8'h03;
   localparam logic [7:0] PAGE_RST = 8'h00;
   // Bits 7:5 of the configuration register read as zero
   localparam logic [7:0] CONFIG_MASK = 8'h1f;

   localparam int unsigned MUX_BIT = 4;
   localparam int unsigned MODE_LSB = 2;
   localparam int unsigned WIDTH_LSB = 0;
   localparam int unsigned STAT_BUSY = 0;
   localparam int unsigned STAT_EXT = 1;

   ////////////////////////////////////////////////////////////////////////
   // Memory modes
   localparam logic [1:0] MODE_INT = 2'h0;
   localparam logic [1:0] MODE_SPLIT_NB = 2'h1;
   localparam logic [1:0] MODE_SPLIT_BS = 2'h2;
   localparam logic [1:0] MODE_EXT = 2'h3;

   // First address above the on-chip data memory
   localparam logic [15:0] ONCHIP_TOP = 16'h1000;

   ////////////////////////////////////////////////////////////////////////
   // Timing: strobe lasts STRB_LAST + 1 cycles, latch phases width + 1
   localparam logic [1:0] STRB_LAST = 2'h2;
   localparam logic [2:0] ALE_ONE = 3'h1;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ALE_HI = 3'b001,
      ST_ALE_LO = 3'b011,
      ST_STRB = 3'b010,
      ST_HOLD = 3'b110,
      ST_DONE = 3'b100,
      ST_INT = 3'b101
   } emlc_state_e;

endpackage

// >>> inc/emlc_mem_if.sv
`timescale 1ns/10ps
interface emlc_mem_if;
   logic en;
   logic we;
   logic [11:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport ctrl (output en, output we, output addr, output wdata,
                 input rdata);
   modport ram (input en, input we, input addr, input wdata,
                output rdata);
endinterface

// >>> hdl/emlc_ram.sv
`timescale 1ns/10ps
module emlc_ram (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   emlc_mem_if.ram mem
);
   logic [7:0] store [0:emlc_pkg::RAM_DEPTH-1];
   logic [7:0] rdata;

   assign mem.rdata = rdata;

   always_ff @(posedge clk_i) begin
      if (ce_i && mem.en && mem.we) begin
         store[mem.addr] <= mem.wdata;
      end
   end

   // Read data always comes out of a register, one cycle after the enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata <= 8'h00;
      end else if (ce_i && mem.en) begin
         rdata <= store[mem.addr];
      end
   end
endmodule

// >>> hdl/emlc_top.sv
// Contract
// - Mode 00 sends every data memory move to on-chip memory, addresses alias.
// - Mode 01 sends addresses below 4 kB on-chip, above it off-chip.
// - Mode 01 8-bit off-chip moves take high byte from port latches.
// - Mode 10 sends addresses below 4 kB on-chip, above it off-chip.
// - Mode 10 8-bit off-chip moves use page register as high byte.
// - Mode 11 sends every move off-chip, on-chip memory invisible.
// - Latch strobe width code n gives n+1 cycles high and low.
// - Latch strobe width matters only when bus mux select is 0.
// - Bus mux select sits at configuration bit 4.
// - Multiplexed mode shares data and low address on eight pins.
// - Multiplexed mode: interface drives the address latch enable output.
// - First multiplexed phase: latch enable high, low address on pins.
// - Second multiplexed phase: data on shared pins during strobe.
// - Non-multiplexed mode drives address and data on separate pins.
// - Bus mux select 0 shares pins, 1 separates them.
// - 8-bit moves use page register as high address byte, except off-chip moves in modes 01 and 11.
// - Internal-only mode wraps addresses on 4 kB boundaries.
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module emlc_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic mv_req_i,
   input wire logic mv_we_i,
   input wire logic mv_wide_i,
   input wire logic [15:0] mv_addr_i,
   input wire logic [7:0] mv_wdata_i,
   output logic [7:0] mv_rdata_o,
   output logic mv_done_o,
   input wire logic [7:0] port_hi_latch_i,
   input wire logic [7:0] ad_i,
   output logic [7:0] ad_o,
   output logic ad_oe_o,
   output logic [7:0] addr_lo_o,
   output logic addr_lo_oe_o,
   output logic [7:0] addr_hi_o,
   output logic addr_hi_oe_o,
   output logic ale_o,
   output logic rd_n_o,
   output logic wr_n_o
);

   ////////////////////////////////////////////////////////////////////////
   // Registers and bus slave
   logic [7:0] cfg;
   logic [7:0] page;
   logic last_ext;
   emlc_pkg::emlc_state_e state;
   emlc_pkg::emlc_state_e next_state;

   wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_hit & wb_we_i & wb_sel_i[0];
   wire cfg_wr = wb_wr & (wb_adr_i == emlc_pkg::REG_CONFIG);
   wire page_wr = wb_wr & (wb_adr_i == emlc_pkg::REG_PAGE);

   wire cfg_mux = cfg[emlc_pkg::MUX_BIT];
   wire [1:0] cfg_mode = cfg[emlc_pkg::MODE_LSB +: 2];
   wire [1:0] cfg_width = cfg[emlc_pkg::WIDTH_LSB +: 2];
   wire busy = (state != emlc_pkg::ST_IDLE);

   wire [7:0] status = {6'h00, last_ext, busy};
   wire [7:0] rd_byte =
      (wb_adr_i == emlc_pkg::REG_CONFIG) ? cfg :
      (wb_adr_i == emlc_pkg::REG_PAGE) ? page :
      (wb_adr_i == emlc_pkg::REG_STATUS) ? status : 8'h00;

   // Unmapped addresses still acknowledge, reading zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= {24'h000000, rd_byte};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg <= emlc_pkg::CONFIG_RST;
         page <= emlc_pkg::PAGE_RST;
      end else if (ce_i) begin
         if (cfg_wr) begin
            cfg <= wb_dat_i[7:0] & emlc_pkg::CONFIG_MASK;
         end
         if (page_wr) begin
            page <= wb_dat_i[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address resolution for a new move
   wire start = (state == emlc_pkg::ST_IDLE) & mv_req_i;
   wire [15:0] eff_addr = mv_wide_i ? mv_addr_i :
                          {page, mv_addr_i[7:0]};
   wire above = (eff_addr >= emlc_pkg::ONCHIP_TOP);
   wire is_split = (cfg_mode == emlc_pkg::MODE_SPLIT_NB) |
                   (cfg_mode == emlc_pkg::MODE_SPLIT_BS);
   // Mode 00 never leaves the chip; mode 11 always does
   wire go_ext = (cfg_mode == emlc_pkg::MODE_EXT) |
                 (is_split & above);
   // Without bank select an 8-bit move leaves the high pins to the ports
   wire hi_from_page = (cfg_mode == emlc_pkg::MODE_SPLIT_BS);
   wire [7:0] fresh_hi = mv_wide_i ? mv_addr_i[15:8] :
                         hi_from_page ? page :
                         port_hi_latch_i;
   wire fresh_hi_oe = mv_wide_i | hi_from_page;

   logic [15:0] act_addr;
   logic act_we;
   logic [7:0] act_wdata;
   logic act_mux;
   logic [1:0] act_width;
   logic act_hi_oe;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_addr <= 16'h0000;
         act_we <= 1'b0;
         act_wdata <= 8'h00;
         act_mux <= 1'b0;
         act_width <= 2'h0;
         act_hi_oe <= 1'b0;
         last_ext <= 1'b0;
      end else if (ce_i && start) begin
         act_addr <= {fresh_hi, eff_addr[7:0]};
         act_we <= mv_we_i;
         act_wdata <= mv_wdata_i;
         act_mux <= cfg_mux;
         act_width <= cfg_width;
         act_hi_oe <= fresh_hi_oe;
         last_ext <= go_ext;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // On-chip memory; the low twelve bits fold higher addresses back
   emlc_mem_if mem ();
   assign mem.en = start & ~go_ext;
   assign mem.we = mv_we_i;
   assign mem.addr = eff_addr[11:0];
   assign mem.wdata = mv_wdata_i;

   emlc_ram u_ram (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .mem(mem.ram)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   logic [1:0] cnt;
   logic [1:0] next_cnt;
   wire [1:0] width_now = start ? cfg_width : act_width;

   always_comb begin
      next_state = state;
      next_cnt = (cnt == 2'h0) ? 2'h0 : cnt - 2'h1;
      case (state)
         emlc_pkg::ST_IDLE: begin
            if (start && !go_ext) begin
               next_state = emlc_pkg::ST_INT;
            end else if (start && cfg_mux) begin
               next_state = emlc_pkg::ST_STRB;
               next_cnt = emlc_pkg::STRB_LAST;
            end else if (start) begin
               next_state = emlc_pkg::ST_ALE_HI;
               next_cnt = width_now;
            end
         end
         emlc_pkg::ST_ALE_HI: begin
            if (cnt == 2'h0) begin
               next_state = emlc_pkg::ST_ALE_LO;
               next_cnt = width_now;
            end
         end
         emlc_pkg::ST_ALE_LO: begin
            if (cnt == 2'h0) begin
               next_state = emlc_pkg::ST_STRB;
               next_cnt = emlc_pkg::STRB_LAST;
            end
         end
         emlc_pkg::ST_STRB: begin
            if (cnt == 2'h0) begin
               next_state = emlc_pkg::ST_HOLD;
            end
         end
         emlc_pkg::ST_HOLD: next_state = emlc_pkg::ST_DONE;
         emlc_pkg::ST_INT: next_state = emlc_pkg::ST_DONE;
         emlc_pkg::ST_DONE: next_state = emlc_pkg::ST_IDLE;
         default: next_state = emlc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= emlc_pkg::ST_IDLE;
         cnt <= 2'h0;
      end else if (ce_i) begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin values, registered from the state being entered
   wire [7:0] lo_now = start ? eff_addr[7:0] : act_addr[7:0];
   wire [7:0] hi_now = start ? fresh_hi : act_addr[15:8];
   wire [7:0] wd_now = start ? mv_wdata_i : act_wdata;
   wire we_now = start ? mv_we_i : act_we;
   wire mux_now = start ? cfg_mux : act_mux;
   wire hi_oe_now = start ? fresh_hi_oe : act_hi_oe;

   wire n_ale = (next_state == emlc_pkg::ST_ALE_HI);
   wire n_addr_ph = n_ale | (next_state == emlc_pkg::ST_ALE_LO);
   wire n_data_ph = (next_state == emlc_pkg::ST_STRB) |
                    (next_state == emlc_pkg::ST_HOLD);
   wire n_ext = n_addr_ph | n_data_ph;
   wire n_strb = (next_state == emlc_pkg::ST_STRB);

   wire next_ad_oe = n_addr_ph | (n_data_ph & we_now);
   wire [7:0] next_ad = n_addr_ph ? lo_now : wd_now;
   wire next_lo_oe = n_data_ph & mux_now;
   wire next_rd_n = ~(n_strb & ~we_now);
   wire next_wr_n = ~(n_strb & we_now);

   // Pin data passes two flops; the strobe is long enough to cover them
   logic [7:0] ad_meta;
   logic [7:0] ad_sync;
   wire rd_take = (state == emlc_pkg::ST_STRB) & (cnt == 2'h0) & ~act_we;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ad_meta <= 8'h00;
         ad_sync <= 8'h00;
      end else if (ce_i) begin
         ad_meta <= ad_i;
         ad_sync <= ad_meta;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ale_o <= 1'b0;
         ad_o <= 8'h00;
         ad_oe_o <= 1'b0;
         addr_lo_o <= 8'h00;
         addr_lo_oe_o <= 1'b0;
         addr_hi_o <= 8'h00;
         addr_hi_oe_o <= 1'b0;
         rd_n_o <= 1'b1;
         wr_n_o <= 1'b1;
      end else if (ce_i) begin
         ale_o <= n_ale;
         ad_o <= next_ad;
         ad_oe_o <= next_ad_oe;
         addr_lo_o <= lo_now;
         addr_lo_oe_o <= next_lo_oe;
         addr_hi_o <= hi_now;
         addr_hi_oe_o <= n_ext & hi_oe_now;
         rd_n_o <= next_rd_n;
         wr_n_o <= next_wr_n;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mv_rdata_o <= 8'h00;
         mv_done_o <= 1'b0;
      end else if (ce_i) begin
         mv_done_o <= (next_state == emlc_pkg::ST_DONE);
         if (state == emlc_pkg::ST_INT && !act_we) begin
            mv_rdata_o <= mem.rdata;
         end else if (rd_take) begin
            mv_rdata_o <= ad_sync;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic [2:0] ale_run;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ale_run <= 3'h0;
      end else if (ce_i) begin
         ale_run <= ale_o ? ale_run + 3'h1 : 3'h0;
      end
   end

   internal_only_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (ce_i && start && cfg_mode == emlc_pkg::MODE_INT) |=>
      state == emlc_pkg::ST_INT)
      else $error("internal mode move left the chip");

   // Folded address rebuilt from the raw move inputs, not from eff_addr
   wrap_addr_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (start && cfg_mode == emlc_pkg::MODE_INT) |->
      mem.en && mem.addr == (mv_wide_i ? mv_addr_i[11:0] :
                             {page[3:0], mv_addr_i[7:0]}))
      else $error("internal address not folded");

   external_only_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (ce_i && start && cfg_mode == emlc_pkg::MODE_EXT) |->
      !mem.en ##1 state != emlc_pkg::ST_INT)
      else $error("external mode used on-chip memory");

   split_route_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (ce_i && start && is_split) |=>
      ((state == emlc_pkg::ST_INT) == !$past(above)))
      else $error("split mode routed the wrong way");

   bank_high_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (ce_i && start && go_ext && !mv_wide_i &&
       cfg_mode == emlc_pkg::MODE_SPLIT_BS) |=>
      addr_hi_oe_o && addr_hi_o == $past(page))
      else $error("bank select high byte not from page");

   ale_width_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      $fell(ale_o) |-> ale_run == {1'b0, act_width} + emlc_pkg::ALE_ONE)
      else $error("latch enable high time wrong");

   no_ale_sep_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (act_mux && busy) |-> !ale_o)
      else $error("latch enable in separate pin mode");

   ale_addr_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      ale_o |-> ad_oe_o && ad_o == act_addr[7:0])
      else $error("low address missing while latch open");

   mux_data_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (!wr_n_o && !act_mux) |-> ad_oe_o && ad_o == act_wdata)
      else $error("write data missing on shared pins");

   one_strobe_a: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (!rd_n_o || !wr_n_o) |-> (rd_n_o || wr_n_o) && !ale_o)
      else $error("strobes overlap or met latch phase");

endmodule

// >>> tb/emlc_ext_mem.sv
`timescale 1ns/10ps
// Transparent low-address latch plus asynchronous byte memory
module emlc_ext_mem (
   input wire logic mux_sel_i,
   input wire logic ale_i,
   input wire logic [7:0] ad_i,
   input wire logic [7:0] addr_lo_i,
   input wire logic [7:0] addr_hi_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   output logic [7:0] dq_o
);
   logic [7:0] lat;
   logic [7:0] last;
   logic [7:0] mem [int];
   wire [15:0] addr = {addr_hi_i, mux_sel_i ? addr_lo_i : lat};

   always_latch begin
      if (ale_i) lat = ad_i;
   end

   always @(posedge wr_n_i) mem[addr] = ad_i;
   always @(negedge rd_n_i) last = mem[addr];

   // Released bus shows the inverse of the last byte, never a held copy
   always @(*) begin
      if (!rd_n_i) dq_o = mem[addr];
      else dq_o = ~last;
   end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
   $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module testbench;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic req = 0, mwe = 0, wide = 0;
   logic [15:0] maddr = 16'h0;
   logic [7:0] mwd = 8'h0, port_hi = 8'h00, e, dq, cur_lo, cur_wd;
   logic [31:0] wb_dat_o;
   logic [7:0] mv_rdata_o, ad_o, addr_lo_o, addr_hi_o;
   logic wb_ack_o, mv_done_o, ad_oe_o, addr_lo_oe_o, addr_hi_oe_o;
   logic ale_o, rd_n_o, wr_n_o, cur_mux = 0, cur_nohi = 0, ce = 1;
   logic [31:0] seed = 32'd52948;
   logic [7:0] exp_q [$];
   int fail_count = 0, n_compared = 0, cycles = 0, hc = 0, lc = 0;
   int cur_w = 3;
   wire [7:0] ad_w = ad_oe_o ? ad_o : dq;
   wire [7:0] lo_w = addr_lo_oe_o ? addr_lo_o : cycles[7:0];
   wire [7:0] hi_w = addr_hi_oe_o ? addr_hi_o : port_hi;

   initial forever #5 clk_i = ~clk_i;

   emlc_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .mv_req_i(req), .mv_we_i(mwe),
      .mv_wide_i(wide), .mv_addr_i(maddr), .mv_wdata_i(mwd),
      .mv_rdata_o(mv_rdata_o), .mv_done_o(mv_done_o),
      .port_hi_latch_i(port_hi), .ad_i(ad_w), .ad_o(ad_o),
      .ad_oe_o(ad_oe_o), .addr_lo_o(addr_lo_o),
      .addr_lo_oe_o(addr_lo_oe_o), .addr_hi_o(addr_hi_o),
      .addr_hi_oe_o(addr_hi_oe_o), .ale_o(ale_o), .rd_n_o(rd_n_o),
      .wr_n_o(wr_n_o));

   emlc_ext_mem ext (.mux_sel_i(cur_mux), .ale_i(ale_o), .ad_i(ad_w),
      .addr_lo_i(lo_w), .addr_hi_i(hi_w), .rd_n_i(rd_n_o),
      .wr_n_i(wr_n_o), .dq_o(dq));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic final_report();
      $display("compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      if (!w) exp_q.push_back(d);
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      cyc <= 0;
      stb <= 0;
      @(posedge clk_i);
   endtask

   task automatic cfg(input logic m, input logic [1:0] md, input int w);
      cur_mux = m;
      cur_w = m ? 3 : w;
      wb(1, 4'h0, {3'h0, m, md, w[1:0]});
   endtask

   // A read passes its expected byte in d
   task automatic mv(input logic w, input logic wd, input logic [15:0] a,
                     input logic [7:0] d, input logic nohi);
      cur_lo = a[7:0];
      cur_wd = d;
      cur_nohi = nohi;
      @(posedge clk_i);
      req <= 1;
      mwe <= w;
      wide <= wd;
      maddr <= a;
      mwd <= w ? d : 8'h00;
      if (!w) exp_q.push_back(d);
      do @(posedge clk_i); while (mv_done_o !== 1'b1);
      req <= 0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(negedge clk_i) begin
      if (wb_ack_o === 1'b1 && !we) begin
         e = exp_q.pop_front();
         `CHK(wb_dat_o, {24'h0, e})
      end
      if (mv_done_o === 1'b1 && !mwe) begin
         e = exp_q.pop_front();
         `CHK(mv_rdata_o, e)
      end
      `CHK(rd_n_o | wr_n_o, 1'b1)
      `CHK(ale_o & cur_mux, 1'b0)
      if (ale_o) begin
         hc++;
         `CHK({ad_oe_o, ad_o}, {1'b1, cur_lo})
      end else if (hc > 0 && rd_n_o && wr_n_o) lc++;
      else if (hc > 0) begin
         `CHK(hc, cur_w + 1)
         `CHK(lc, cur_w + 1)
         hc = 0;
         lc = 0;
      end
      if (!wr_n_o) `CHK({ad_oe_o, ad_o}, {1'b1, cur_wd})
      if (!(rd_n_o && wr_n_o)) begin
         `CHK(addr_lo_oe_o, cur_mux)
         if (cur_mux) `CHK(addr_lo_o, cur_lo)
         if (cur_nohi) `CHK(addr_hi_oe_o, 1'b0)
      end
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] a;
      logic [7:0] d;
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      wb(0, 4'h0, 8'h03);
      wb(0, 4'h4, 8'h00);
      wb(0, 4'h8, 8'h00);
      wb(1, 4'h0, 8'hff);
      wb(0, 4'h0, 8'h1f);
      wb(0, 4'hc, 8'h00);
      // Every latch width, then separate pins with width ignored
      for (int i = 0; i < 5; i++) begin
         cfg(i == 4, 2'h3, i);
         a = rnd();
         d = rnd();
         mv(1, 1, a, d, 0);
         mv(0, 1, a, d, 0);
      end
      cfg(0, 2'h3, 1);
      mv(1, 1, 16'h0010, 8'ha1, 0);
      cfg(1, 2'h0, 0);
      mv(1, 1, 16'h1010, 8'hb2, 0);
      mv(0, 1, 16'h0010, 8'hb2, 0);
      cfg(0, 2'h3, 0);
      mv(0, 1, 16'h0010, 8'ha1, 0);
      cfg(0, 2'h1, 2);
      mv(0, 1, 16'h0010, 8'hb2, 0);
      mv(1, 1, 16'h1010, 8'hc3, 0);
      cfg(1, 2'h2, 0);
      mv(0, 1, 16'h0010, 8'hb2, 0);
      // Freeze the sequencer in mid-strobe; the read must still land
      fork
         mv(0, 1, 16'h1010, 8'hc3, 0);
         begin
            @(negedge rd_n_o);
            @(posedge clk_i);
            ce <= 0;
            repeat (3) @(posedge clk_i);
            ce <= 1;
         end
      join
      wb(1, 4'h4, 8'h20);
      mv(1, 0, 16'h0005, 8'hd4, 0);
      wb(1, 4'h4, 8'h00);
      mv(1, 0, 16'h0007, 8'he5, 0);
      cfg(0, 2'h1, 0);
      wb(1, 4'h4, 8'h30);
      port_hi <= 8'h40;
      mv(1, 0, 16'h0006, 8'hf6, 1);
      cfg(0, 2'h3, 0);
      mv(0, 1, 16'h2005, 8'hd4, 0);
      mv(0, 1, 16'h4006, 8'hf6, 0);
      wb(0, 4'h8, 8'h02);
      cfg(1, 2'h0, 0);
      mv(0, 1, 16'h0007, 8'he5, 0);
      repeat (4) @(posedge clk_i);
      `CHK(exp_q.size(), 0)
      final_report();
   end
endmodule
